// ===== decp_counter_pins.v
// Purpose: Dual 40-bit event counters, control register and indicator pins
// Assumes: Model-register port requests are one-clock pulses on ref_clk
// Notes:   Registers are selected by index; only privilege level 0 may access
`timescale 1ns/1ns
`include "decp_defines.vh"

module decp_counter_pins (
    input  wire                          ref_clk,
    input  wire                          resetn,
    input  wire [`DECP_CPL_W-1:0]        currentPrivilegeLevel,
    input  wire                          modelRegisterRead,
    input  wire                          modelRegisterWrite,
    input  wire [`DECP_SEL_W-1:0]        modelRegisterSelect,
    input  wire [`DECP_DATA_W-1:0]       modelRegisterWriteData,
    input  wire [`DECP_NUM_EVENTS-1:0]   eventActive,
    input  wire [`DECP_NUM_EVENTS-1:0]   eventSecond,
    input  wire                          breakpointPinMode,
    input  wire [1:0]                    breakpointMatch,
    output reg  [`DECP_DATA_W-1:0]       modelRegisterReadData,
    output reg                           modelRegisterDone,
    output reg                           modelRegisterFault,
    output reg                           indicatorPinZero,
    output reg                           indicatorPinOne
);

    // --------------------------------------------------------------
    // Control register
    // --------------------------------------------------------------
    reg  [`DECP_CTL_W-1:0]  counterControlSelect;

    wire [`DECP_CODE_W-1:0] eventCodeZero;
    wire [`DECP_CODE_W-1:0] eventCodeOne;
    wire [`DECP_MODE_W-1:0] countModeZero;
    wire [`DECP_MODE_W-1:0] countModeOne;
    wire                    pinFunctionZero;
    wire                    pinFunctionOne;

    assign eventCodeZero   = counterControlSelect[`DECP_CODE0_HI:`DECP_CODE0_LO];
    assign eventCodeOne    = counterControlSelect[`DECP_CODE1_HI:`DECP_CODE1_LO];
    assign countModeZero   = counterControlSelect[`DECP_MODE0_HI:`DECP_MODE0_LO];
    assign countModeOne    = counterControlSelect[`DECP_MODE1_HI:`DECP_MODE1_LO];
    assign pinFunctionZero = counterControlSelect[`DECP_PIN0_BIT];
    assign pinFunctionOne  = counterControlSelect[`DECP_PIN1_BIT];

    // --------------------------------------------------------------
    // Access decode
    // --------------------------------------------------------------
    wire                    request;
    wire                    privileged;
    wire                    selectValid;
    wire                    accessOk;
    wire                    writeControl;
    wire                    writeZero;
    wire                    writeOne;

    assign request      = modelRegisterRead | modelRegisterWrite;
    assign privileged   = (currentPrivilegeLevel == `DECP_CPL_KERNEL);
    assign selectValid  = (modelRegisterSelect == `DECP_SEL_CTRL) |
                          (modelRegisterSelect == `DECP_SEL_CNT0) |
                          (modelRegisterSelect == `DECP_SEL_CNT1);
    assign accessOk     = privileged & selectValid;
    assign writeControl = modelRegisterWrite & accessOk &
                          (modelRegisterSelect == `DECP_SEL_CTRL);
    assign writeZero    = modelRegisterWrite & accessOk &
                          (modelRegisterSelect == `DECP_SEL_CNT0);
    assign writeOne     = modelRegisterWrite & accessOk &
                          (modelRegisterSelect == `DECP_SEL_CNT1);

    // --------------------------------------------------------------
    // Counters
    // --------------------------------------------------------------
    wire [`DECP_CNT_W-1:0]  eventCounterZero;
    wire [`DECP_CNT_W-1:0]  eventCounterOne;
    wire [1:0]              pinRaw;

    decp_event_counter counterZero (
        .ref_clk               (ref_clk),
        .resetn                (resetn),
        .countMode             (countModeZero),
        .eventCode             (eventCodeZero),
        .pinFunction           (pinFunctionZero),
        .currentPrivilegeLevel (currentPrivilegeLevel),
        .eventActive           (eventActive),
        .eventSecond           (eventSecond),
        .writeEnable           (writeZero),
        .writeValue            (modelRegisterWriteData[`DECP_CNT_W-1:0]),
        .count                 (eventCounterZero),
        .pinRaw                (pinRaw[0])
    );

    decp_event_counter counterOne (
        .ref_clk               (ref_clk),
        .resetn                (resetn),
        .countMode             (countModeOne),
        .eventCode             (eventCodeOne),
        .pinFunction           (pinFunctionOne),
        .currentPrivilegeLevel (currentPrivilegeLevel),
        .eventActive           (eventActive),
        .eventSecond           (eventSecond),
        .writeEnable           (writeOne),
        .writeValue            (modelRegisterWriteData[`DECP_CNT_W-1:0]),
        .count                 (eventCounterOne),
        .pinRaw                (pinRaw[1])
    );

    // --------------------------------------------------------------
    // Control register write and reset
    // --------------------------------------------------------------
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            counterControlSelect <= `DECP_CTL_RESET;
        end else if (writeControl) begin
            counterControlSelect <= modelRegisterWriteData[`DECP_CTL_W-1:0];
        end
    end

    // --------------------------------------------------------------
    // Read mux and access answer
    // --------------------------------------------------------------
    reg  [`DECP_DATA_W-1:0] readValue;

    always @* begin
        readValue = `DECP_DATA_ZERO;
        case (modelRegisterSelect)
            `DECP_SEL_CTRL: begin
                readValue = {`DECP_CTL_PAD, counterControlSelect};
            end
            `DECP_SEL_CNT0: begin
                readValue = {`DECP_CNT_PAD, eventCounterZero};
            end
            `DECP_SEL_CNT1: begin
                readValue = {`DECP_CNT_PAD, eventCounterOne};
            end
            default: begin
                readValue = `DECP_DATA_ZERO;
            end
        endcase
    end

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            modelRegisterReadData <= `DECP_DATA_ZERO;
            modelRegisterDone     <= 1'b0;
            modelRegisterFault    <= 1'b0;
        end else begin
            modelRegisterDone  <= request;
            modelRegisterFault <= request & ~accessOk;
            if (modelRegisterRead & accessOk) begin
                modelRegisterReadData <= readValue;
            end else if (request) begin
                modelRegisterReadData <= `DECP_DATA_ZERO;
            end
        end
    end

    // --------------------------------------------------------------
    // Pin latch and buffer stages
    // --------------------------------------------------------------
    reg  [`DECP_PIPE_DEPTH-1:0] pipeZero;
    reg  [`DECP_PIPE_DEPTH-1:0] pipeOne;
    reg  [1:0]                  breakpointHeld;

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pipeZero       <= {`DECP_PIPE_DEPTH{1'b0}};
            pipeOne        <= {`DECP_PIPE_DEPTH{1'b0}};
            breakpointHeld <= 2'h0;
        end else begin
            pipeZero       <= {pipeZero[`DECP_PIPE_DEPTH-2:0], pinRaw[0]};
            pipeOne        <= {pipeOne[`DECP_PIPE_DEPTH-2:0], pinRaw[1]};
            breakpointHeld <= breakpointMatch;
        end
    end

    // --------------------------------------------------------------
    // Pin drivers: counter signalling or breakpoint indication
    // --------------------------------------------------------------
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            indicatorPinZero <= 1'b0;
            indicatorPinOne  <= 1'b0;
        end else if (breakpointPinMode) begin
            indicatorPinZero <= breakpointHeld[0];
            indicatorPinOne  <= breakpointHeld[1];
        end else begin
            indicatorPinZero <= pipeZero[`DECP_PIPE_DEPTH-2];
            indicatorPinOne  <= pipeOne[`DECP_PIPE_DEPTH-2];
        end
    end

endmodule

// ===== decp_defines.vh
// Purpose: Shared constants for the dual event counter block
// Assumes: Included by every design file of the block
// Notes:   Selector and timing values are named here once
`ifndef DECP_DEFINES_VH
`define DECP_DEFINES_VH

// --------------------------------------------------------------
// Widths
// --------------------------------------------------------------
`define DECP_CTL_W       32
`define DECP_CNT_W       40
`define DECP_DATA_W      64
`define DECP_NUM_EVENTS  64
`define DECP_CODE_W      6
`define DECP_MODE_W      3
`define DECP_INC_W       2
`define DECP_SEL_W       2
`define DECP_CPL_W       2

// --------------------------------------------------------------
// Control register fields
// --------------------------------------------------------------
`define DECP_CODE0_HI    5
`define DECP_CODE0_LO    0
`define DECP_MODE0_HI    8
`define DECP_MODE0_LO    6
`define DECP_PIN0_BIT    9
`define DECP_CODE1_HI    21
`define DECP_CODE1_LO    16
`define DECP_MODE1_HI    24
`define DECP_MODE1_LO    22
`define DECP_PIN1_BIT    25

// Mode field bits
`define DECP_MODE_CLK    2
`define DECP_MODE_USR    1
`define DECP_MODE_SYS    0

// --------------------------------------------------------------
// Register selectors on the model-register port
// --------------------------------------------------------------
`define DECP_SEL_CTRL    2'h0
`define DECP_SEL_CNT0    2'h1
`define DECP_SEL_CNT1    2'h2

// --------------------------------------------------------------
// Privilege levels and reset values
// --------------------------------------------------------------
`define DECP_CPL_KERNEL  2'h0
`define DECP_CPL_USER    2'h3
`define DECP_CTL_RESET   32'h00000000
`define DECP_CNT_RESET   40'h0000000000
`define DECP_DATA_ZERO   64'h0000000000000000
`define DECP_CTL_PAD     32'h00000000
`define DECP_CNT_PAD     24'h000000
`define DECP_INC_ZERO    2'h0

// --------------------------------------------------------------
// Pin timing: event cycle to pin, in clocks
// --------------------------------------------------------------
`define DECP_PIN_DELAY   5
`define DECP_PIPE_DEPTH  4

`endif

// ===== decp_event_counter.v
// Purpose: One 40-bit event or duration counter with pin source
// Assumes: Mode, code and pin function come from the control register
// Notes:   A register write wins over a count in the same clock
`timescale 1ns/1ns
`include "decp_defines.vh"

module decp_event_counter (
    input  wire                          ref_clk,
    input  wire                          resetn,
    input  wire [`DECP_MODE_W-1:0]       countMode,
    input  wire [`DECP_CODE_W-1:0]       eventCode,
    input  wire                          pinFunction,
    input  wire [`DECP_CPL_W-1:0]        currentPrivilegeLevel,
    input  wire [`DECP_NUM_EVENTS-1:0]   eventActive,
    input  wire [`DECP_NUM_EVENTS-1:0]   eventSecond,
    input  wire                          writeEnable,
    input  wire [`DECP_CNT_W-1:0]        writeValue,
    output reg  [`DECP_CNT_W-1:0]        count,
    output reg                           pinRaw
);

    // --------------------------------------------------------------
    // Enable and increment
    // --------------------------------------------------------------
    wire                  isUser;
    wire                  enabled;
    wire                  hit;
    wire                  hitTwice;
    reg  [`DECP_INC_W-1:0] inc;
    wire [`DECP_CNT_W:0]  sum;
    wire                  carry;

    assign isUser   = (currentPrivilegeLevel == `DECP_CPL_USER);
    // Codes 000 and 100 have neither privilege bit set
    assign enabled  = isUser ? countMode[`DECP_MODE_USR]
                             : countMode[`DECP_MODE_SYS];
    assign hit      = eventActive[eventCode];
    assign hitTwice = eventSecond[eventCode];

    always @* begin
        inc = `DECP_INC_ZERO;
        if (enabled) begin
            if (countMode[`DECP_MODE_CLK]) begin
                inc = {1'b0, hit};
            end else begin
                inc = {hit & hitTwice, hit & ~hitTwice};
            end
        end
    end

    assign sum   = {1'b0, count} + {{(`DECP_CNT_W-1){1'b0}}, inc};
    assign carry = sum[`DECP_CNT_W];

    // --------------------------------------------------------------
    // Count register and raw pin source
    // --------------------------------------------------------------
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            count  <= `DECP_CNT_RESET;
            pinRaw <= 1'b0;
        end else begin
            if (writeEnable) begin
                count  <= writeValue;
                pinRaw <= 1'b0;
            end else begin
                count  <= sum[`DECP_CNT_W-1:0];
                if (pinFunction) begin
                    pinRaw <= carry;
                end else begin
                    pinRaw <= (inc != `DECP_INC_ZERO);
                end
            end
        end
    end

endmodule

// ===== decp_counter_pins_props.sv
// Purpose: Port-level checks for the dual event counter block
// Assumes: Single clock domain, async active-low reset
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ns
module decp_counter_pins_props (
    input wire        ref_clk,
    input wire        resetn,
    input wire [1:0]  currentPrivilegeLevel,
    input wire        modelRegisterRead,
    input wire        modelRegisterWrite,
    input wire [1:0]  modelRegisterSelect,
    input wire [63:0] modelRegisterReadData,
    input wire        modelRegisterDone,
    input wire        modelRegisterFault,
    input wire        breakpointPinMode,
    input wire [1:0]  breakpointMatch,
    input wire        indicatorPinZero,
    input wire        indicatorPinOne
);
    // ----------------------------------------------------------
    // Register port and pin checks
    // ----------------------------------------------------------
    wire req;
    wire kern;
    assign req = modelRegisterRead | modelRegisterWrite;
    assign kern = (currentPrivilegeLevel == 2'h0) && (modelRegisterSelect != 2'h3);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    chk_done_after_req: assert property (req |=> modelRegisterDone)
        else $error("done missing after request");
    chk_no_stray_done: assert property (!req |=> !modelRegisterDone)
        else $error("done without request");
    chk_fault_user_level: assert property ((req && currentPrivilegeLevel != 2'h0) |=> modelRegisterFault)
        else $error("user level access not refused");
    chk_fault_bad_select: assert property ((req && modelRegisterSelect == 2'h3) |=> modelRegisterFault && modelRegisterReadData == 64'h0)
        else $error("bad select not refused");
    chk_kernel_no_fault: assert property ((req && kern) |=> !modelRegisterFault)
        else $error("kernel access refused");
    chk_fault_with_done: assert property (modelRegisterFault |-> modelRegisterDone)
        else $error("fault without done");
    chk_ctl_upper_zero: assert property ((modelRegisterRead && !modelRegisterWrite && kern && modelRegisterSelect == 2'h0) |=> modelRegisterReadData[63:32] == 32'h0)
        else $error("control upper bits not zero");
    chk_cnt_upper_zero: assert property ((modelRegisterRead && kern && modelRegisterSelect != 2'h0) |=> modelRegisterReadData[63:40] == 24'h0)
        else $error("counter upper bits not zero");
    chk_data_holds_idle: assert property (!req |=> $stable(modelRegisterReadData))
        else $error("read data changed without request");
    chk_break_pins: assert property (breakpointPinMode [*3] |-> {indicatorPinOne, indicatorPinZero} == $past(breakpointMatch, 2))
        else $error("pins do not follow breakpoint matches");
endmodule
bind decp_counter_pins decp_counter_pins_props i_props (
    .ref_clk(ref_clk), .resetn(resetn), .currentPrivilegeLevel(currentPrivilegeLevel),
    .modelRegisterRead(modelRegisterRead), .modelRegisterWrite(modelRegisterWrite),
    .modelRegisterSelect(modelRegisterSelect), .modelRegisterReadData(modelRegisterReadData),
    .modelRegisterDone(modelRegisterDone), .modelRegisterFault(modelRegisterFault),
    .breakpointPinMode(breakpointPinMode), .breakpointMatch(breakpointMatch),
    .indicatorPinZero(indicatorPinZero), .indicatorPinOne(indicatorPinOne));

// ===== decp_pin_monitor.sv
// Purpose: Pin watcher standing in for external monitoring hardware
// Assumes: Pins are sampled on the rising clock edge
// Notes:   Counts clocks with each pin high; cleared only by reset
`timescale 1ns/1ns
module decp_pin_monitor (
    input  wire       ref_clk,
    input  wire       resetn,
    input  wire       pinZero,
    input  wire       pinOne,
    output reg  [7:0] highZero,
    output reg  [7:0] highOne
);
    // Latched pins are only looked at on clock edges
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            highZero <= 8'h00;
            highOne <= 8'h00;
        end else begin
            highZero <= highZero + {7'h00, pinZero};
            highOne <= highOne + {7'h00, pinOne};
        end
    end
endmodule

// ===== decp_counter_pins_tb_top.sv
// Purpose: Self-checking bench for the dual event counter block
// Assumes: Register access by one-clock read or write pulses
// Notes:   Pin counts come from the pin monitor
`timescale 1ns/1ns
module decp_counter_pins_tb_top;
    logic        ref_clk, resetn, modelRegisterRead, modelRegisterWrite, breakpointPinMode;
    logic [1:0]  currentPrivilegeLevel, modelRegisterSelect, breakpointMatch;
    logic [63:0] modelRegisterWriteData, eventActive, eventSecond, rdData;
    wire  [63:0] modelRegisterReadData;
    wire         modelRegisterDone, modelRegisterFault, indicatorPinZero, indicatorPinOne;
    wire  [7:0]  highZero, highOne;
    logic [7:0]  baseZero, baseOne, seen;
    logic        fault;
    integer      fail_count, checked, m, lvl, n, k;

    decp_counter_pins i_dut (.ref_clk(ref_clk), .resetn(resetn),
        .currentPrivilegeLevel(currentPrivilegeLevel), .modelRegisterRead(modelRegisterRead),
        .modelRegisterWrite(modelRegisterWrite), .modelRegisterSelect(modelRegisterSelect),
        .modelRegisterWriteData(modelRegisterWriteData), .eventActive(eventActive),
        .eventSecond(eventSecond), .breakpointPinMode(breakpointPinMode),
        .breakpointMatch(breakpointMatch), .modelRegisterReadData(modelRegisterReadData),
        .modelRegisterDone(modelRegisterDone), .modelRegisterFault(modelRegisterFault),
        .indicatorPinZero(indicatorPinZero), .indicatorPinOne(indicatorPinOne));
    decp_pin_monitor i_mon (.ref_clk(ref_clk), .resetn(resetn), .pinZero(indicatorPinZero),
        .pinOne(indicatorPinOne), .highZero(highZero), .highOne(highOne));

    // ----------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------
    task check(input string name, input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task access(input logic wr, input logic [1:0] sel, input logic [63:0] data,
                input logic [1:0] current_privilege_level);
        @(posedge ref_clk);
        modelRegisterWrite <= wr;
        modelRegisterRead <= !wr;
        modelRegisterSelect <= sel;
        modelRegisterWriteData <= data;
        currentPrivilegeLevel <= current_privilege_level;
        @(posedge ref_clk);
        modelRegisterWrite <= 1'h0;
        modelRegisterRead <= 1'h0;
        currentPrivilegeLevel <= 2'h0;
        #1;
        check("done", modelRegisterDone, 64'h1);
        rdData = modelRegisterReadData;
        fault = modelRegisterFault;
    endtask
    task print_verdict;
        $display("Comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ----------------------------------------------------------
    // Clock, watchdog and sequence
    // ----------------------------------------------------------
    initial begin
        ref_clk = 1'h0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        print_verdict;
    end
    initial begin
        fail_count = 0;
        checked = 0;
        resetn = 1'h0;
        {modelRegisterRead, modelRegisterWrite, breakpointPinMode} = 3'h0;
        {currentPrivilegeLevel, modelRegisterSelect, breakpointMatch} = 6'h00;
        {modelRegisterWriteData, eventActive, eventSecond} = 192'h0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'h1;
        for (k = 0; k < 3; k++) begin
            access(1'h0, k[1:0], 64'h0, 2'h0);
            check("reset value", rdData, 64'h0);
        end
        access(1'h1, 2'h0, 64'hffffffffffffffff, 2'h0);
        access(1'h0, 2'h0, 64'h0, 2'h0);
        check("control fields", rdData, 64'hffffffff);
        access(1'h1, 2'h0, 64'h0, 2'h0);
        access(1'h1, 2'h1, 64'hffffffffffffffff, 2'h0);
        access(1'h0, 2'h1, 64'h0, 2'h0);
        check("counter preset", rdData, 64'hffffffffff);
        access(1'h1, 2'h0, 64'h1, 2'h3);
        check("user fault", fault, 64'h1);
        access(1'h0, 2'h0, 64'h0, 2'h0);
        check("user write ignored", rdData, 64'h0);
        access(1'h0, 2'h3, 64'h0, 2'h0);
        check("select fault", {fault, rdData[62:0]}, 64'h8000000000000000);
        for (m = 0; m < 8; m++) begin
            for (lvl = 0; lvl < 4; lvl += 3) begin
                access(1'h1, 2'h0, 64'h0, 2'h0);
                access(1'h1, 2'h1, 64'h0, 2'h0);
                access(1'h1, 2'h2, 64'h0, 2'h0);
                access(1'h1, 2'h0, {32'h0, 7'h00, m[2:0], 6'h02, 7'h00, m[2:0], 6'h01}, 2'h0);
                baseZero = highZero;
                baseOne = highOne;
                @(posedge ref_clk);
                currentPrivilegeLevel <= lvl[1:0];
                eventActive <= 64'h6;
                eventSecond <= 64'h6;
                repeat (3) @(posedge ref_clk);
                currentPrivilegeLevel <= 2'h0;
                eventActive <= 64'h0;
                eventSecond <= 64'h0;
                repeat (8) @(posedge ref_clk);
                n = ((lvl == 3) ? m[1] : m[0]) ? 3 : 0;
                access(1'h0, 2'h1, 64'h0, 2'h0);
                check("count zero", rdData, m[2] ? n : 2 * n);
                access(1'h0, 2'h2, 64'h0, 2'h0);
                check("count one", rdData, m[2] ? n : 2 * n);
                check("pin zero", highZero - baseZero, n);
                check("pin one", highOne - baseOne, n);
            end
        end
        access(1'h1, 2'h0, 64'h0, 2'h0);
        access(1'h1, 2'h1, 64'hffffffffff, 2'h0);
        access(1'h1, 2'h0, 64'h2c1, 2'h0);
        @(posedge ref_clk);
        eventActive <= 64'h2;
        for (k = 0; k < 8; k++) begin
            @(posedge ref_clk);
            if (k == 1)
                eventActive <= 64'h0;
            #1;
            seen[k] = indicatorPinZero;
        end
        check("overflow pin", seen, 64'h10);
        access(1'h0, 2'h1, 64'h0, 2'h0);
        check("wrapped count", rdData, 64'h1);
        @(posedge ref_clk);
        breakpointPinMode <= 1'h1;
        breakpointMatch <= 2'h2;
        repeat (3) @(posedge ref_clk);
        #1;
        check("breakpoint pins", {indicatorPinOne, indicatorPinZero}, 64'h2);
        breakpointPinMode <= 1'h0;
        breakpointMatch <= 2'h0;
        repeat (4) @(posedge ref_clk);
        print_verdict;
    end
endmodule
